// >>> rtl/vrc_pkg.sv
// vrc_pkg: register address, field positions and carrier types for the
// voltage reference control block.
// assumes an 8-bit special-function register bus with address, strobes.
package vrc_pkg;

   localparam int          VRC_DATA_W       = 8;
   localparam int          VRC_ADDR_W       = 8;
   localparam logic [7:0]  VRC_ADDR_REFCTL  = 8'hD1;
   localparam logic [7:0]  VRC_RESET_REFCTL = 8'h00;
   localparam logic [7:0]  VRC_WRITE_MASK   = 8'h0F;
   localparam int          VRC_BIT_BUF      = 0;
   localparam int          VRC_BIT_BIAS     = 1;
   localparam int          VRC_BIT_TEMP     = 2;
   localparam int          VRC_BIT_SRC      = 3;
   localparam int          VRC_NUM_USERS    = 4;

   // reference source encoding
   typedef enum logic {
      VRC_SRC_PIN    = 1'b0,
      VRC_SRC_SUPPLY = 1'b1
   } vrc_src_t;

   // special-function register access
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } vrc_sfr_req_t;

   // analog control outputs
   typedef struct packed {
      vrc_src_t reference_source_select;
      logic     temp_sensor_enable;
      logic     bias_generator_enable;
      logic     reference_buffer_enable;
   } vrc_analog_t;

endpackage : vrc_pkg

// >>> rtl/vrc_bias_force.sv
// vrc_bias_force: combines the manual bias bit with the peripheral
// enables that need the bias generator running.
// assumes enables are synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module vrc_bias_force
   import vrc_pkg::*;
#(
   parameter int NUM_USERS = VRC_NUM_USERS
) (
   input  wire logic [NUM_USERS-1:0] user_enable,
   input  wire logic                 manual_enable,
   output logic                      bias_on
);

   if (NUM_USERS < 1) begin : g_chk
      $error("vrc_bias_force: NUM_USERS must be at least 1");
   end

   always_comb begin
      bias_on = manual_enable | (|user_enable);
   end

endmodule : vrc_bias_force
`default_nettype wire

// >>> rtl/vrc_reference_control.sv
// vrc_reference_control: reference control register and its analog enables.
// assumes register accesses are synchronous to clk_sys, one per strobe.
// assumes bias_user_enable levels come from peripherals on the same clock.
// a read and a write in one cycle: the read shows the contents before it.
// analog_ctl and the read port come straight from flip-flops.
`timescale 1ns/1ps
`default_nettype none
module vrc_reference_control
   import vrc_pkg::*;
#(
   parameter int NUM_USERS = VRC_NUM_USERS
) (
   input  wire logic                  clk_sys,
   input  wire logic                  reset,
   input  wire vrc_sfr_req_t          sfr_req,
   input  wire logic [NUM_USERS-1:0]  bias_user_enable,
   output logic [VRC_DATA_W-1:0]      sfr_rdata,
   output logic                       sfr_sel,
   output vrc_analog_t                analog_ctl
);

   ////////////////////////////////////////////////////////////////////////
   // control bits sit at the bottom; everything above them reads zero
   localparam int CTRL_W             = VRC_BIT_SRC + 1;
   localparam int FIELD_POS [CTRL_W] = '{VRC_BIT_BUF, VRC_BIT_BIAS, VRC_BIT_TEMP, VRC_BIT_SRC};

   if (NUM_USERS < 1) begin : g_chk
      $error("vrc_reference_control: NUM_USERS must be at least 1");
   end

   if (CTRL_W > VRC_DATA_W) begin : g_chk_width
      $error("vrc_reference_control: control bits do not fit the register");
   end

   if ($bits(vrc_analog_t) != CTRL_W) begin : g_chk_analog
      $error("vrc_reference_control: one analog enable per control bit");
   end

   if ((VRC_RESET_REFCTL & ~VRC_WRITE_MASK) != '0) begin : g_chk_reset
      $error("vrc_reference_control: reset value sets a bit that reads zero");
   end

   if ((VRC_WRITE_MASK >> CTRL_W) != '0) begin : g_chk_mask
      $error("vrc_reference_control: writable bit above the control field");
   end

   if ($bits(VRC_ADDR_REFCTL) != VRC_ADDR_W) begin : g_chk_addr
      $error("vrc_reference_control: register address width mismatch");
   end

   // each field must be writable and own a bit of its own
   for (genvar f = 0; f < CTRL_W; f++) begin : g_field_chk
      if (!VRC_WRITE_MASK[FIELD_POS[f]]) begin : g_ro
         $error("vrc_reference_control: a control field is not writable");
      end
      for (genvar g = f + 1; g < CTRL_W; g++) begin : g_pair
         if (FIELD_POS[f] == FIELD_POS[g]) begin : g_same
            $error("vrc_reference_control: two control fields share a bit");
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register state and its next value
   logic [VRC_DATA_W-1:0] reference_control;
   logic [VRC_DATA_W-1:0] next_reference_control;

   // fields as they will stand after this edge
   logic                  next_src_sel;
   logic                  next_temp_en;
   logic                  next_bias_manual;
   logic                  next_buf_en;

   // fields as they stand now
   logic                  src_sel;
   logic                  temp_en;
   logic                  bias_manual;
   logic                  buf_en;

   // read path: next values and what a read would show
   logic [VRC_DATA_W-1:0] next_sfr_rdata;
   logic                  next_sfr_sel;
   logic [VRC_DATA_W-1:0] read_view;

   // analog enables, next value
   vrc_analog_t           next_analog_ctl;

   // access decode and bias demand
   logic                  hit;
   logic                  wr_hit;
   logic                  rd_hit;
   wire  [NUM_USERS:0]    user_chain;
   logic                  user_active;
   logic                  bias_on;

   ////////////////////////////////////////////////////////////////////////
   // access decode; other addresses get no answer at all
   always_comb begin
      hit    = (sfr_req.addr == VRC_ADDR_REFCTL);
      wr_hit = hit & sfr_req.wr;
      rd_hit = hit & sfr_req.rd;
   end

   // one stage per peripheral that needs the bias generator
   assign user_chain[0] = 1'h0;
   for (genvar u = 0; u < NUM_USERS; u++) begin : g_user
      assign user_chain[u+1] = user_chain[u] | bias_user_enable[u];
   end

   always_comb begin
      user_active = user_chain[NUM_USERS];
   end

   ////////////////////////////////////////////////////////////////////////
   // bias enable: the manual bit or any peripheral user enable
   vrc_bias_force #(
      .NUM_USERS (NUM_USERS)
   ) u_bias (
      .user_enable   (bias_user_enable),
      .manual_enable (next_bias_manual),
      .bias_on       (bias_on)
   );

   ////////////////////////////////////////////////////////////////////////
   // control register; unused bits keep their reset value
   always_comb begin
      for (int b = 0; b < VRC_DATA_W; b++) begin
         if (!VRC_WRITE_MASK[b]) begin
            next_reference_control[b] = VRC_RESET_REFCTL[b];
         end else if (wr_hit) begin
            next_reference_control[b] = sfr_req.wdata[b];
         end else begin
            next_reference_control[b] = reference_control[b];
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         reference_control <= VRC_RESET_REFCTL;
      end else begin
         reference_control <= next_reference_control;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // fields by name, so the enables never lag a write by a cycle
   always_comb begin
      next_src_sel     = next_reference_control[VRC_BIT_SRC];
      next_temp_en     = next_reference_control[VRC_BIT_TEMP];
      next_bias_manual = next_reference_control[VRC_BIT_BIAS];
      next_buf_en      = next_reference_control[VRC_BIT_BUF];
   end

   always_comb begin
      src_sel     = reference_control[VRC_BIT_SRC];
      temp_en     = reference_control[VRC_BIT_TEMP];
      bias_manual = reference_control[VRC_BIT_BIAS];
      buf_en      = reference_control[VRC_BIT_BUF];
   end

   ////////////////////////////////////////////////////////////////////////
   // enables follow the register; bias also follows its users
   always_comb begin
      next_analog_ctl.reference_source_select = vrc_src_t'(next_src_sel);
      next_analog_ctl.temp_sensor_enable = next_temp_en;
      next_analog_ctl.bias_generator_enable = bias_on;
      next_analog_ctl.reference_buffer_enable = next_buf_en;
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         analog_ctl <= '0;
      end else begin
         analog_ctl <= next_analog_ctl;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read path; the stored bias bit stays as written, only its view is forced
   always_comb begin
      read_view               = '0;
      read_view[VRC_BIT_SRC]  = src_sel;
      read_view[VRC_BIT_TEMP] = temp_en;
      read_view[VRC_BIT_BIAS] = bias_manual | user_active;
      read_view[VRC_BIT_BUF]  = buf_en;
      next_sfr_sel            = rd_hit;
      next_sfr_rdata          = sfr_rdata;
      if (rd_hit) begin
         next_sfr_rdata = read_view;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sfr_rdata <= VRC_RESET_REFCTL;
         sfr_sel   <= 1'h0;
      end else begin
         sfr_rdata <= next_sfr_rdata;
         sfr_sel   <= next_sfr_sel;
      end
   end

endmodule : vrc_reference_control
`default_nettype wire

// >>> tb/vrc_chk.sv
// vrc_chk: assertions at the block ports; one clk_sys domain.
`timescale 1ns/1ps
`default_nettype none
module vrc_chk import vrc_pkg::*; #(parameter int NUM_USERS = 4) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire vrc_sfr_req_t sfr_req,
   input wire logic [NUM_USERS-1:0] bias_user_enable,
   input wire logic [7:0] sfr_rdata,
   input wire logic sfr_sel,
   input wire vrc_analog_t analog_ctl);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   sequence s_wr; sfr_req.wr && sfr_req.addr == VRC_ADDR_REFCTL; endsequence
   sequence s_rd; sfr_req.rd && sfr_req.addr == VRC_ADDR_REFCTL; endsequence
   a_rd_bias: assert property (s_rd ##0 (|bias_user_enable) |=> sfr_rdata[1])
      else $error("bias read not forced");
   a_sel_idle: assert property (!(sfr_req.rd && sfr_req.addr == VRC_ADDR_REFCTL) |=> !sfr_sel)
      else $error("answer without read");
   a_src_wr: assert property (s_wr |=> analog_ctl[3] == $past(sfr_req.wdata[3]))
      else $error("source bit");
   a_bias_usr: assert property (|bias_user_enable |=> analog_ctl[1])
      else $error("bias not forced");
   a_bias_man: assert property (s_wr ##0 sfr_req.wdata[1] |=> analog_ctl[1])
      else $error("bias not set");
   a_buf_wr: assert property (s_wr |=> analog_ctl[0] == $past(sfr_req.wdata[0]))
      else $error("buffer bit");
   a_temp_wr: assert property (s_wr |=> analog_ctl[2] == $past(sfr_req.wdata[2]))
      else $error("sensor bit");
   a_rd_hi: assert property (sfr_req.rd && sfr_req.addr == VRC_ADDR_REFCTL |=>
      sfr_sel && sfr_rdata[7:4] == 4'h0) else $error("read answer");
   a_rst_clr: assert property ($fell(reset) |-> analog_ctl == 4'h0)
      else $error("reset value");
endmodule : vrc_chk
bind vrc_reference_control vrc_chk #(.NUM_USERS(NUM_USERS)) i_chk (
   .clk_sys          (clk_sys),
   .reset            (reset),
   .sfr_req          (sfr_req),
   .bias_user_enable (bias_user_enable),
   .sfr_rdata        (sfr_rdata),
   .sfr_sel          (sfr_sel),
   .analog_ctl       (analog_ctl)
);
`default_nettype wire

// >>> tb/vrc_reference_control_tb.sv
// vrc_reference_control_tb: random traffic against a model; checker bound.
`timescale 1ns/1ps
`default_nettype none
module vrc_reference_control_tb import vrc_pkg::*; ;
   logic clk_sys = 1'h0, reset = 1'h1, sfr_sel;
   logic [3:0] users = 4'h0, m = 4'h0;
   logic [7:0] sfr_rdata, e, r = 8'h00;
   vrc_sfr_req_t sfr_req = '0;
   vrc_analog_t analog_ctl;
   int errors = 0, cmp_count = 0, cyc = 0;
   vrc_reference_control i_dut (.clk_sys, .reset, .sfr_req, .bias_user_enable(users),
      .sfr_rdata, .sfr_sel, .analog_ctl);
   initial forever #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (++cyc == 2000) begin
      errors++;
      end_sim();
   end
   task automatic chk(logic [7:0] s, logic [7:0] x);
      cmp_count++;
      errors += int'(s !== x);
      if (s !== x) $display("CHECK FAILED %0t got %h want %h", $time, s, x);
   endtask : chk
   task automatic end_sim();
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_sim
   initial begin
      void'($urandom(96599));
      repeat (16) @(negedge clk_sys);
      chk({4'h0, analog_ctl}, 8'h00);
      reset = 1'h0;
      repeat (200) begin
         users = 4'($urandom);
         sfr_req = {$urandom % 4 ? VRC_ADDR_REFCTL : 8'hD0, 2'h2, 8'($urandom)};
         if (sfr_req.addr == VRC_ADDR_REFCTL) m = sfr_req.wdata[3:0];
         e = {4'h0, m[3:2], m[1] | (|users), m[0]};
         @(negedge clk_sys);
         sfr_req = {$urandom % 4 ? VRC_ADDR_REFCTL : 8'hD0, 2'h1, 8'h00};
         chk({4'h0, analog_ctl}, e);
         chk({7'h0, sfr_sel}, 8'h00);
         @(negedge clk_sys);
         if (sfr_req.addr == VRC_ADDR_REFCTL) r = e;
         chk({7'h0, sfr_sel}, {7'h0, sfr_req.addr == VRC_ADDR_REFCTL});
         chk(sfr_rdata, r);
      end
      // second reset in mid-run, then a supply reference with the buffer left off
      reset = 1'h1;
      sfr_req = '0;
      m = 4'h0;
      r = 8'h00;
      @(negedge clk_sys);
      chk({4'h0, analog_ctl}, 8'h00);
      chk(sfr_rdata, r);
      reset = 1'h0;
      users = 4'h0;
      sfr_req = {VRC_ADDR_REFCTL, 2'h2, 8'hF8};
      @(negedge clk_sys);
      sfr_req = {VRC_ADDR_REFCTL, 2'h1, 8'h00};
      chk({4'h0, analog_ctl}, 8'h08);
      @(negedge clk_sys);
      chk(sfr_rdata, 8'h08);
      end_sim();
   end
endmodule : vrc_reference_control_tb
`default_nettype wire
